// file: tc_pkg.sv
package tc_pkg;

  // timer modes
  typedef enum logic [2:0] {
    mode_pulse,
    mode_ext_pulse,
    mode_on_delay,
    mode_stored_on_delay,
    mode_off_delay
  } timer_mode_t;

  // timer constant: three bcd digits plus a two-bit base code
  typedef struct packed {
    logic [1:0]  base;
    logic [11:0] value;
  } timer_constant_t;

  // per-scan inputs from the user program
  typedef struct packed {
    logic logic_result_bit;
    logic timer_reset;
    logic counter_set;
    logic counter_reset;
    logic increment_input;
    logic decrement_input;
    logic latch_set;
    logic latch_reset;
    logic shot_input;
  } scan_in_t;

  localparam int          VALUE_W       = 10;
  localparam int          BCD_W         = 12;
  localparam int          NUM_CELLS     = 256;
  localparam int          CELL_ADDR_W   = 8;
  localparam logic [9:0]  COUNT_MAX     = 10'h3E7;
  localparam logic [9:0]  VALUE_ZERO    = 10'h000;
  localparam logic [1:0]  BASE_10MS     = 2'h0;
  localparam logic [1:0]  BASE_100MS    = 2'h1;
  localparam logic [1:0]  BASE_1S       = 2'h2;
  localparam logic [1:0]  BASE_10S      = 2'h3;
  localparam logic [3:0]  BCD_NINE      = 4'h9;

endpackage

// file: tc_bcd_reg.sv
`timescale 1ns/1ps
`default_nettype none
// registered binary to bcd conversion of a 0..999 value
module tc_bcd_reg (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [9:0]   bin,
  output var  logic [11:0]  bcd
);
  import tc_pkg::*;

  logic [11:0] bcd_d;
  logic [11:0] bcd_q;

  always_comb begin
    bcd_d = 12'h000;
    for (int i = 9; i >= 0; i--) begin
      if (bcd_d[3:0] > 4'h4) bcd_d[3:0] = bcd_d[3:0] + 4'h3;
      if (bcd_d[7:4] > 4'h4) bcd_d[7:4] = bcd_d[7:4] + 4'h3;
      if (bcd_d[11:8] > 4'h4) bcd_d[11:8] = bcd_d[11:8] + 4'h3;
      bcd_d = {bcd_d[10:0], bin[i]};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bcd_q <= 12'h000;
    end else if (ce) begin
      bcd_q <= bcd_d;
    end
  end

  assign bcd = bcd_q;

endmodule
`default_nettype wire

// file: plc_timer_counter_cell.sv
`timescale 1ns/1ps
`default_nettype none
module plc_timer_counter_cell #(
  parameter logic [7:0] CELL_NUMBER = 8'h00
) (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     ce,
  input  wire logic                     scan_strobe,
  input  wire logic                     tick_10ms,
  input  wire logic                     tick_100ms,
  input  wire logic                     tick_1s,
  input  wire logic                     tick_10s,
  input  wire tc_pkg::timer_mode_t      mode,
  input  wire tc_pkg::timer_constant_t  timer_constant,
  input  wire logic [11:0]              counter_preset,
  input  wire tc_pkg::scan_in_t         scan_in,
  output var  logic                     timer_status,
  output var  logic [9:0]               raw_value_out,
  output var  logic [13:0]              bcd_value_out,
  output var  logic                     counter_status,
  output var  logic [9:0]               count_raw_out,
  output var  logic [11:0]              count_bcd_out,
  output var  logic                     latch_out,
  output var  logic                     shot_pulse
);
  import tc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // bcd to binary, 0..999
  // worked at 12 bits so a bad digit above 999 saturates instead of wrapping
  function automatic logic [9:0] bcd2bin(input logic [11:0] b);
    logic [11:0] s;
    s = 12'({8'h00, b[11:8]} * 12'h064 + {8'h00, b[7:4]} * 12'h00A + {8'h00, b[3:0]});
    bcd2bin = (s > 12'h3E7) ? COUNT_MAX : s[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // timer
  logic [9:0]  tval_q, tval_d;
  logic        run_q, run_d;
  logic        done_q, done_d;
  logic        edge_q, edge_d;
  logic [1:0]  base_q, base_d;
  logic        tstat_q, tstat_d;
  logic        tick;
  logic        lrb;

  assign lrb = scan_in.logic_result_bit;

  always_comb begin
    unique case (base_q)
      BASE_10MS:  tick = tick_10ms;
      BASE_100MS: tick = tick_100ms;
      BASE_1S:    tick = tick_1s;
      BASE_10S:   tick = tick_10s;
    endcase
  end

  always_comb begin
    logic start;
    start  = 1'b0;
    tval_d = tval_q;
    run_d  = run_q;
    done_d = done_q;
    edge_d = edge_q;
    base_d = base_q;
    // the first tick may come right after a start, so a time can run up to a whole base tick short; short bases are the precise ones
    if (run_q && tick) begin
      if (tval_q <= 10'h001) begin
        tval_d = VALUE_ZERO;
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        tval_d = tval_q - 10'h001;
      end
    end
    if (scan_strobe) begin
      edge_d = lrb;
      unique case (mode)
        mode_off_delay: start = edge_q && !lrb;
        default:        start = lrb && !edge_q;
      endcase
      if (start) begin
        tval_d = bcd2bin(timer_constant.value);
        base_d = timer_constant.base;
        run_d  = (bcd2bin(timer_constant.value) != VALUE_ZERO);
        done_d = (bcd2bin(timer_constant.value) == VALUE_ZERO);
      end
      if (!lrb && (mode == mode_pulse || mode == mode_on_delay)) begin
        tval_d = VALUE_ZERO;
        run_d  = 1'b0;
        done_d = 1'b0;
      end
      if (lrb && mode == mode_off_delay) begin
        tval_d = VALUE_ZERO;
        run_d  = 1'b0;
        done_d = 1'b0;
      end
      if (scan_in.timer_reset) begin
        tval_d = VALUE_ZERO;
        run_d  = 1'b0;
        done_d = 1'b0;
      end
    end
    unique case (mode)
      mode_pulse, mode_ext_pulse: tstat_d = run_d;
      mode_on_delay:              tstat_d = done_d && (scan_strobe ? lrb : edge_q);
      mode_stored_on_delay:       tstat_d = done_d;
      mode_off_delay:             tstat_d = run_d || (scan_strobe ? lrb : edge_q);
      default:                    tstat_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tval_q  <= VALUE_ZERO;
      run_q   <= 1'b0;
      done_q  <= 1'b0;
      edge_q  <= 1'b0;
      base_q  <= BASE_10MS;
      tstat_q <= 1'b0;
    end else if (ce) begin
      tval_q  <= tval_d;
      run_q   <= run_d;
      done_q  <= done_d;
      edge_q  <= edge_d;
      base_q  <= base_d;
      tstat_q <= tstat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter; edge flags live beside the count as in a counter word
  logic [9:0] cnt_q, cnt_d;
  logic       set_edge_q, set_edge_d;
  logic       up_edge_q, up_edge_d;
  logic       dn_edge_q, dn_edge_d;

  always_comb begin
    cnt_d      = cnt_q;
    set_edge_d = set_edge_q;
    up_edge_d  = up_edge_q;
    dn_edge_d  = dn_edge_q;
    if (scan_strobe) begin
      set_edge_d = scan_in.counter_set;
      up_edge_d  = scan_in.increment_input;
      dn_edge_d  = scan_in.decrement_input;
      if (scan_in.increment_input && !up_edge_q && cnt_q < COUNT_MAX) begin
        cnt_d = cnt_q + 10'h001;
      end
      if (scan_in.decrement_input && !dn_edge_q && cnt_d > VALUE_ZERO) begin
        cnt_d = cnt_d - 10'h001;
      end
      if (scan_in.counter_set && !set_edge_q) begin
        cnt_d = bcd2bin(counter_preset);
        if (bcd2bin(counter_preset) > COUNT_MAX) cnt_d = COUNT_MAX;
      end
      if (scan_in.counter_reset) begin
        cnt_d = VALUE_ZERO;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q      <= VALUE_ZERO;
      set_edge_q <= 1'b0;
      up_edge_q  <= 1'b0;
      dn_edge_q  <= 1'b0;
    end else if (ce) begin
      cnt_q      <= cnt_d;
      set_edge_q <= set_edge_d;
      up_edge_q  <= up_edge_d;
      dn_edge_q  <= dn_edge_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latch and one-shot
  logic latch_q, latch_d;
  logic shot_edge_q, shot_edge_d;
  logic shot_q, shot_d;

  always_comb begin
    latch_d     = latch_q;
    shot_edge_d = shot_edge_q;
    shot_d      = shot_q;
    if (scan_strobe) begin
      if (scan_in.latch_set) latch_d = 1'b1;
      // reset is evaluated last, so it wins
      if (scan_in.latch_reset) latch_d = 1'b0;
      shot_d      = scan_in.shot_input && !shot_edge_q;
      shot_edge_d = scan_in.shot_input;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_q     <= 1'b0;
      shot_edge_q <= 1'b0;
      shot_q      <= 1'b0;
    end else if (ce) begin
      latch_q     <= latch_d;
      shot_edge_q <= shot_edge_d;
      shot_q      <= shot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic [11:0] tbcd;
  logic [11:0] cbcd;
  logic [1:0]  base_o_q;
  logic [9:0]  traw_q;
  logic [9:0]  craw_q;
  logic        cstat_q;

  tc_bcd_reg u_tbcd (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .bin    (tval_q),
    .bcd    (tbcd)
  );

  tc_bcd_reg u_cbcd (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .bin    (cnt_q),
    .bcd    (cbcd)
  );

  // raw values delayed one cycle so binary and bcd outputs change together
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_o_q <= BASE_10MS;
      traw_q   <= VALUE_ZERO;
      craw_q   <= VALUE_ZERO;
      cstat_q  <= 1'b0;
    end else if (ce) begin
      base_o_q <= base_q;
      traw_q   <= tval_q;
      craw_q   <= cnt_q;
      cstat_q  <= (cnt_q != VALUE_ZERO);
    end
  end

  assign timer_status   = tstat_q;
  assign raw_value_out  = traw_q;
  assign bcd_value_out  = {base_o_q, tbcd};
  assign counter_status = cstat_q;
  assign count_raw_out  = craw_q;
  assign count_bcd_out  = cbcd;
  assign latch_out      = latch_q;
  assign shot_pulse     = shot_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_pulse_drop;
    @(posedge clk) disable iff (!resetn)
      (ce && scan_strobe && mode == mode_pulse && !lrb && !scan_in.timer_reset) |=> !run_q && !tstat_q;
  endproperty
  a_pulse_drop: assert property (p_pulse_drop) else $error("pulse not cleared");

  property p_pulse_status;
    @(posedge clk) disable iff (!resetn)
      (mode == mode_pulse && $stable(mode) && ce) |=> (tstat_q == (tval_q != VALUE_ZERO));
  endproperty
  a_pulse_status: assert property (p_pulse_status) else $error("pulse status wrong");

  property p_retrigger;
    @(posedge clk) disable iff (!resetn)
      (ce && scan_strobe && lrb && edge_q && run_q && !tick && !scan_in.timer_reset && mode != mode_off_delay)
        |=> $stable(tval_q);
  endproperty
  a_retrigger: assert property (p_retrigger) else $error("retrigger changed timer");

  property p_countdown;
    @(posedge clk) disable iff (!resetn)
      (ce && run_q && tick && !scan_strobe && tval_q > 10'h001) |=> tval_q == $past(tval_q) - 10'h001;
  endproperty
  a_countdown: assert property (p_countdown) else $error("timer did not decrement");

  property p_off_hold;
    @(posedge clk) disable iff (!resetn)
      (ce && scan_strobe && mode == mode_off_delay && lrb) |=> !run_q && tstat_q;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("off delay not held");

  property p_count_max;
    @(posedge clk) disable iff (!resetn) cnt_q <= COUNT_MAX;
  endproperty
  a_count_max: assert property (p_count_max) else $error("count above limit");

  property p_latch_reset;
    @(posedge clk) disable iff (!resetn)
      (ce && scan_strobe && scan_in.latch_reset) |=> !latch_q && !latch_out;
  endproperty
  a_latch_reset: assert property (p_latch_reset) else $error("latch reset lost");

  sequence s_shot_rise;
    ce && scan_strobe && scan_in.shot_input && !shot_edge_q;
  endsequence
  property p_shot;
    @(posedge clk) disable iff (!resetn)
      s_shot_rise ##1 (ce && scan_strobe) |=> !shot_q;
  endproperty
  a_shot: assert property (p_shot) else $error("one shot too long");

  property p_set_level;
    @(posedge clk) disable iff (!resetn)
      (ce && scan_strobe && set_edge_q && !scan_in.counter_reset && !scan_in.increment_input
       && !scan_in.decrement_input) |=> $stable(cnt_q);
  endproperty
  a_set_level: assert property (p_set_level) else $error("counter reloaded on level");

endmodule
`default_nettype wire

// file: tc_user_program.sv
`timescale 1ns/1ps
`default_nettype none
// user program: one scan strobe per request, scan word only valid in that cycle
module tc_user_program (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             req,
  input  wire tc_pkg::scan_in_t cmd,
  output var  logic             scan_strobe,
  output var  tc_pkg::scan_in_t scan_in
);
  import tc_pkg::*;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scan_strobe <= 1'b0;
      scan_in     <= '0;
    end else if (req) begin
      scan_strobe <= 1'b1;
      scan_in     <= cmd;
    end else begin
      scan_strobe <= 1'b0;
      // between scans the word is stale, so wiggle it to catch off-strobe sampling
      scan_in     <= ~scan_in;
    end
  end
endmodule
`default_nettype wire

// file: plc_timer_counter_cell_tb.sv
`timescale 1ns/1ps
`default_nettype none
module plc_timer_counter_cell_tb;
  import tc_pkg::*;
  localparam logic [8:0] LRB = 9'h100, TRS = 9'h080, CSET = 9'h040, CRST = 9'h020, INC = 9'h010;
  localparam logic [8:0] DEC = 9'h008, LSET = 9'h004, LRST = 9'h002, SHOT = 9'h001;
  logic            clk = 1'b0;
  logic            resetn = 1'b0;
  logic            ce = 1'b1;
  logic            req = 1'b0;
  scan_in_t        cmd = '0;
  logic [3:0]      tick = 4'h0;
  timer_mode_t     mode = mode_pulse;
  timer_constant_t kt = '0;
  logic [11:0]     preset = 12'h000;
  logic            strobe;
  scan_in_t        sin;
  logic            t_st, c_st, latch, shot;
  logic [9:0]      t_raw, c_raw;
  logic [13:0]     t_bcd;
  logic [11:0]     c_bcd;
  int              miscompares = 0;
  int              total_checks = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  tc_user_program i_tc_user_program (.clk(clk), .resetn(resetn), .req(req), .cmd(cmd),
    .scan_strobe(strobe), .scan_in(sin));

  plc_timer_counter_cell i_plc_timer_counter_cell (.clk(clk), .resetn(resetn), .ce(ce),
    .scan_strobe(strobe), .tick_10ms(tick[0]), .tick_100ms(tick[1]), .tick_1s(tick[2]),
    .tick_10s(tick[3]), .mode(mode), .timer_constant(kt), .counter_preset(preset),
    .scan_in(sin), .timer_status(t_st), .raw_value_out(t_raw), .bcd_value_out(t_bcd),
    .counter_status(c_st), .count_raw_out(c_raw), .count_bcd_out(c_bcd),
    .latch_out(latch), .shot_pulse(shot));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // outputs settle within two cycles after the scan is taken, so wait four
  task automatic scan(input logic [8:0] v);
    @(posedge clk) req <= 1'b1;
    cmd <= scan_in_t'(v);
    @(posedge clk) req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // two scans back to back: the second strobe follows the first directly
  task automatic scan2(input logic [8:0] a, input logic [8:0] b);
    @(posedge clk) req <= 1'b1;
    cmd <= scan_in_t'(a);
    @(posedge clk) cmd <= scan_in_t'(b);
    @(posedge clk) req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic tk(input int b, input int n);
    repeat (n) begin
      @(posedge clk) tick[b] <= 1'b1;
      @(posedge clk) tick[b] <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask

  task automatic setup(input timer_mode_t m, input logic [1:0] b, input logic [11:0] v);
    @(posedge clk) mode <= m;
    kt <= '{base: b, value: v};
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_pulse;
    setup(mode_pulse, BASE_10MS, 12'h003);
    scan(LRB);
    chk("p_st", t_st, 1);
    chk("p_raw", t_raw, 3);
    tk(0, 1);
    scan(LRB);
    chk("p_keep", t_raw, 2);
    tk(1, 1);
    chk("p_base", t_raw, 2);
    scan(0);
    chk("p_clr", t_st, 0);
    scan(LRB);
    tk(0, 3);
    chk("p_end", t_st, 0);
    chk("p_zero", t_raw, 0);
  endtask

  task automatic t_on;
    setup(mode_on_delay, BASE_100MS, 12'h012);
    scan(0);
    scan(LRB);
    chk("o_st0", t_st, 0);
    chk("o_raw", t_raw, 10'h00C);
    chk("o_bcd", t_bcd, 14'h1012);
    tk(1, 12);
    scan(LRB);
    chk("o_st1", t_st, 1);
    scan(0);
    chk("o_clr", t_st, 0);
    chk("o_clrv", t_raw, 0);
  endtask

  task automatic t_stored;
    setup(mode_stored_on_delay, BASE_1S, 12'h001);
    scan(LRB);
    scan(0);
    chk("s_run", t_st, 0);
    tk(2, 1);
    scan(0);
    chk("s_hold", t_st, 1);
    scan(TRS);
    chk("s_rst", t_st, 0);
  endtask

  task automatic t_ext;
    setup(mode_ext_pulse, BASE_10S, 12'h002);
    scan(LRB);
    chk("e_bcd", t_bcd, 14'h3002);
    scan(0);
    chk("e_st", t_st, 1);
    tk(3, 2);
    chk("e_end", t_st, 0);
  endtask

  task automatic t_off;
    setup(mode_off_delay, BASE_10MS, 12'h002);
    scan(LRB);
    chk("f_in", t_st, 1);
    chk("f_held", t_raw, 0);
    scan(0);
    chk("f_run", t_st, 1);
    chk("f_load", t_raw, 2);
    tk(0, 2);
    chk("f_end", t_st, 0);
  endtask

  task automatic t_count;
    @(posedge clk) preset <= 12'h998;
    scan(CSET);
    chk("c_raw", c_raw, 10'h3E6);
    chk("c_bcd", c_bcd, 12'h998);
    chk("c_st", c_st, 1);
    scan(CSET | INC);
    chk("c_lvl", c_raw, 10'h3E7);
    scan(0);
    scan(INC);
    chk("c_max", c_bcd, 12'h999);
    scan(0);
    scan(DEC);
    chk("c_dn", c_raw, 10'h3E6);
    scan(CRST);
    chk("c_rst", c_st, 0);
    scan(0);
    scan(DEC);
    chk("c_min", c_raw, 0);
  endtask

  task automatic t_latch_shot;
    scan(LSET);
    chk("l_set", latch, 1);
    scan(0);
    chk("l_keep", latch, 1);
    scan(LRST);
    chk("l_rst", latch, 0);
    scan(LSET | LRST);
    chk("l_both", latch, 0);
    scan(SHOT);
    chk("o_one", shot, 1);
    scan(SHOT);
    chk("o_once", shot, 0);
    scan(0);
    scan(SHOT);
    chk("o_again", shot, 1);
    scan(0);
    scan2(SHOT, SHOT);
    chk("o_b2b", shot, 0);
    scan2(LRST, LSET);
    chk("l_b2b", latch, 1);
  endtask

  // clock enable low must freeze the running timer against ticks
  task automatic t_ce;
    setup(mode_ext_pulse, BASE_10MS, 12'h005);
    scan(LRB);
    @(posedge clk) ce <= 1'b0;
    tk(0, 2);
    @(posedge clk) ce <= 1'b1;
    #1;
    chk("z_hold", t_raw, 5);
    chk("z_st", t_st, 1);
    tk(0, 1);
    chk("z_run", t_raw, 4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_pulse();
    t_on();
    t_stored();
    t_ext();
    t_off();
    t_count();
    t_latch_shot();
    t_ce();
    summarize();
  end

  // about 40 scans and 25 ticks of under 10 cycles each; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
